// ---- design/sar_pkg.sv ----
`default_nettype none
package sar_pkg;
  localparam int CTRL_W = 8;
  localparam int RES_W = 12;
  localparam int CH_W = 3;
  // control byte field positions
  localparam int PD_HI_BIT = 7;
  localparam int PD_LO_BIT = 6;
  localparam int ACQ_BIT = 5;
  localparam int ENDED_BIT = 4;
  localparam int POL_BIT = 3;
  localparam int CH_LSB = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  // synchronised pin vector: {clk pin, high byte, rd_n, wr_n, cs_n}
  localparam int PIN_W = 5;
  localparam int PIN_CS = 0;
  localparam int PIN_WR = 1;
  localparam int PIN_RD = 2;
  localparam int PIN_HB = 3;
  localparam int PIN_CLK = 4;
  localparam logic [PIN_W-1:0] PIN_RST = 5'h07;
  // timing
  localparam int CONV_CYCLES = 13;
  localparam int ACQ_EDGES = 4;
  localparam int CLK_SYS_HZ = 25_000_000;
  localparam int INT_CONV_NS = 3600;
  // longest tick period, rounded down
  localparam int INT_DIV = (INT_CONV_NS * (CLK_SYS_HZ / 1_000_000)) /
                           (1000 * CONV_CYCLES);
  localparam logic [RES_W-1:0] SAR_START = 12'h800;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_ACQ_INT = 4'h2,
    ST_ACQ_EXT = 4'h4,
    ST_CONV    = 4'h8
  } seq_state_e;
endpackage
`default_nettype wire

// ---- design/pin_sync.sv ----
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
  logic [W-1:0] lvl_nxt, rise_nxt, fall_nxt;

  // a level change is accepted only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
      rise_nxt[i] = lvl_nxt[i] & ~lvl_r[i];
      fall_nxt[i] = ~lvl_nxt[i] & lvl_r[i];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      lvl_r <= RST;
      rise_r <= '0;
      fall_r <= '0;
    end
    else if (clk_en)
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign lvl = lvl_r;
  assign rise = rise_r;
  assign fall = fall_r;
endmodule
`default_nettype wire

// ---- design/sar_adc_control_sequencer.sv ----
// Contract
// (R1) a qualified write rising edge, other than the one closing an external acquisition, puts the sampler into tracking
// (R2) external acquisition: next write rising edge switches to hold
// (R3) internal acquisition: hold on fourth falling conversion-clock edge
// (R4) a conversion not aborted by a write lasts exactly 13 conversion-clock cycles
// (R5) write during conversion aborts it and starts new acquisition
// (R6) acquire bit clear: one write acquires then converts automatically
// (R7) external: host writes bit set, then cleared; conversion on second
// (R8) host keeps channel bits unchanged between the two external writes
// (R9) done flag driven low when result is ready
// (R10) done flag returns high on first read or any write
// (R11) power bits: 00 off, 01 standby, 10 internal clock, 11 external
// (R12) bit five selects internal or external acquisition timing
// (R13) bit four selects pseudo-differential or single-ended inputs
// (R14) bit three selects bipolar or unipolar range
// (R15) three low bits select the channel or channel pair
// (R16) single-ended negative input is common return, else pair partner
// (R17) reset selects external clock and holds done flag high
// (R18) high byte read gives upper four bits plus sign or zero fill
// (R19) chip select high ignores clock, write, read; bus floats
// (R20) successive approximation resolves bits MSB first, one per cycle
// (R21) unipolar result straight binary, bipolar two's complement
`default_nettype none
module sar_adc_control_sequencer #(
  parameter int INT_DIV = sar_pkg::INT_DIV
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic high_byte_select,
  input wire logic conv_clk_pin,
  input wire logic [sar_pkg::CTRL_W-1:0] data_in,
  input wire logic cmp_in,
  output logic [sar_pkg::CTRL_W-1:0] data_out,
  output logic data_oe_n,
  output logic done_n,
  output logic hold_capacitor_track,
  output logic [sar_pkg::RES_W-1:0] dac_code,
  output logic [sar_pkg::CH_W-1:0] pos_channel,
  output logic [sar_pkg::CH_W-1:0] neg_channel,
  output logic neg_to_common,
  output logic full_power_down,
  output logic standby,
  output logic int_clk_sel
);
  ////////////////////////////////////////////////////////////////////////
  logic [sar_pkg::PIN_W-1:0] pins, pin_lvl, pin_rise, pin_fall;
  logic [sar_pkg::CTRL_W-1:0] wr_data;
  logic cs_act, wr_ev, rd_ev, tick, finish;

  assign pins = {conv_clk_pin, high_byte_select, rd_n, wr_n, cs_n};

  pin_sync #(.W(sar_pkg::PIN_W), .RST(sar_pkg::PIN_RST)) u_pin_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .clk_en(clk_en),
    .d(pins),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // data shares the pin latency so it lines up with the write edge;
  // the host must hold it steady a few clk_sys cycles around that edge
  pin_sync #(.W(sar_pkg::CTRL_W), .RST(sar_pkg::CTRL_RST)) u_data_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .clk_en(clk_en),
    .d(data_in),
    .lvl(wr_data),
    .rise(),
    .fall()
  );

  assign cs_act = ~pin_lvl[sar_pkg::PIN_CS];
  assign wr_ev = cs_act & pin_rise[sar_pkg::PIN_WR]; // R19
  assign rd_ev = cs_act & pin_fall[sar_pkg::PIN_RD]; // R19

  ////////////////////////////////////////////////////////////////////////
  sar_pkg::seq_state_e state_r, state_nxt;
  logic [sar_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [sar_pkg::RES_W-1:0] sar_r, sar_nxt, result_r, result_nxt;
  logic [sar_pkg::CTRL_W-1:0] dout_r, dout_nxt;
  logic [3:0] cnt_r, cnt_nxt, bit_idx;
  logic [7:0] div_r, div_nxt;
  logic int_clk_r, int_clk_nxt, track_r, track_nxt, done_n_r, done_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic tick_int, pol_uni;
  // decoded outputs are registered from the next control byte
  logic [sar_pkg::CH_W-1:0] neg_r, neg_nxt;
  logic fpd_r, fpd_nxt, stby_r, stby_nxt;

  assign tick_int = (div_r == 8'(INT_DIV - 1));
  // external clock edges count only while selected
  assign tick = int_clk_r ? tick_int
              : (cs_act & pin_fall[sar_pkg::PIN_CLK]); // R19
  assign bit_idx = 4'(sar_pkg::RES_W - 1) - cnt_r;
  assign finish = ~wr_ev && (state_r == sar_pkg::ST_CONV) && tick &&
                  (cnt_r == 4'(sar_pkg::CONV_CYCLES - 1));
  assign pol_uni = ctrl_r[sar_pkg::POL_BIT]; // R14

  always_comb
  begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    sar_nxt = sar_r;
    result_nxt = result_r;
    cnt_nxt = cnt_r;
    int_clk_nxt = int_clk_r;
    track_nxt = track_r;
    done_n_nxt = done_n_r;
    div_nxt = (int_clk_r && !tick_int) ? div_r + 8'h01 : 8'h00;
    if (rd_ev)
      done_n_nxt = 1'b1; // R10
    if (wr_ev)
    begin
      done_n_nxt = 1'b1; // R10
      ctrl_nxt = wr_data;
      cnt_nxt = 4'h0;
      if (wr_data[sar_pkg::PD_HI_BIT])
      begin
        int_clk_nxt = ~wr_data[sar_pkg::PD_LO_BIT]; // R11
        if (state_r == sar_pkg::ST_ACQ_EXT)
        begin
          // second write closes the open acquisition
          state_nxt = sar_pkg::ST_CONV; // R2 R7
          track_nxt = 1'b0; // R2
          sar_nxt = sar_pkg::SAR_START;
        end
        else if (wr_data[sar_pkg::ACQ_BIT])
        begin
          state_nxt = sar_pkg::ST_ACQ_EXT; // R12
          track_nxt = 1'b1; // R1
        end
        else
        begin
          state_nxt = sar_pkg::ST_ACQ_INT; // R5 R6 R12
          track_nxt = 1'b1; // R1
        end
      end
      else
      begin
        // power-down keeps the clock source and stops converting
        state_nxt = sar_pkg::ST_IDLE; // R11
        track_nxt = 1'b1; // R1
      end
    end
    else
    begin
      case (state_r)
        sar_pkg::ST_ACQ_INT:
          if (tick)
          begin
            if (cnt_r == 4'(sar_pkg::ACQ_EDGES - 1))
            begin
              state_nxt = sar_pkg::ST_CONV; // R3 R6
              track_nxt = 1'b0; // R3
              cnt_nxt = 4'h0;
              sar_nxt = sar_pkg::SAR_START;
            end
            else
              cnt_nxt = cnt_r + 4'h1;
          end
        sar_pkg::ST_CONV:
          if (tick)
          begin
            if (cnt_r == 4'(sar_pkg::CONV_CYCLES - 1))
            begin
              state_nxt = sar_pkg::ST_IDLE; // R4
              done_n_nxt = 1'b0; // R9
              cnt_nxt = 4'h0;
              // dac runs offset binary; flip msb for two's complement
              result_nxt = pol_uni ? sar_r
                         : {~sar_r[sar_pkg::RES_W-1],
                            sar_r[sar_pkg::RES_W-2:0]}; // R21
            end
            else
            begin
              cnt_nxt = cnt_r + 4'h1; // R4
              if (cnt_r < 4'(sar_pkg::RES_W))
              begin
                if (!cmp_in)
                  sar_nxt[bit_idx] = 1'b0; // R20
                if (bit_idx != 4'h0)
                  sar_nxt[bit_idx - 4'h1] = 1'b1; // R20
              end
            end
          end
        default:
          ;
      endcase
    end
    oe_n_nxt = ~cs_act | pin_lvl[sar_pkg::PIN_RD]; // R19
    if (pin_lvl[sar_pkg::PIN_HB])
      dout_nxt = {{4{~pol_uni & result_r[sar_pkg::RES_W-1]}},
                  result_r[sar_pkg::RES_W-1:8]}; // R18
    else
      dout_nxt = result_r[7:0]; // R18
    neg_nxt = ctrl_nxt[sar_pkg::CH_LSB +: sar_pkg::CH_W] ^ 3'h1; // R16
    fpd_nxt = ~ctrl_nxt[sar_pkg::PD_HI_BIT] &
              ~ctrl_nxt[sar_pkg::PD_LO_BIT]; // R11
    stby_nxt = ~ctrl_nxt[sar_pkg::PD_HI_BIT] &
               ctrl_nxt[sar_pkg::PD_LO_BIT]; // R11
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_r <= sar_pkg::ST_IDLE;
      ctrl_r <= sar_pkg::CTRL_RST;
      sar_r <= '0;
      result_r <= '0;
      cnt_r <= 4'h0;
      div_r <= 8'h00;
      int_clk_r <= 1'b0; // R17
      track_r <= 1'b0;
      done_n_r <= 1'b1; // R17
      oe_n_r <= 1'b1;
      dout_r <= 8'h00;
      neg_r <= sar_pkg::CTRL_RST[sar_pkg::CH_LSB +: sar_pkg::CH_W] ^ 3'h1;
      fpd_r <= ~sar_pkg::CTRL_RST[sar_pkg::PD_HI_BIT] &
               ~sar_pkg::CTRL_RST[sar_pkg::PD_LO_BIT];
      stby_r <= ~sar_pkg::CTRL_RST[sar_pkg::PD_HI_BIT] &
                sar_pkg::CTRL_RST[sar_pkg::PD_LO_BIT];
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      sar_r <= sar_nxt;
      result_r <= result_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      int_clk_r <= int_clk_nxt;
      track_r <= track_nxt;
      done_n_r <= done_n_nxt;
      oe_n_r <= oe_n_nxt;
      dout_r <= dout_nxt;
      neg_r <= neg_nxt;
      fpd_r <= fpd_nxt;
      stby_r <= stby_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign data_out = dout_r;
  assign data_oe_n = oe_n_r;
  assign done_n = done_n_r;
  assign hold_capacitor_track = track_r;
  assign dac_code = sar_r;
  assign int_clk_sel = int_clk_r;
  assign pos_channel = ctrl_r[sar_pkg::CH_LSB +: sar_pkg::CH_W]; // R15
  assign neg_to_common = ctrl_r[sar_pkg::ENDED_BIT]; // R13 R16
  assign neg_channel = neg_r; // R16
  assign full_power_down = fpd_r; // R11
  assign standby = stby_r; // R11

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || !clk_en);

  a_track_on_write: assert property ( // R1
    wr_ev && state_r != sar_pkg::ST_ACQ_EXT |=> track_r)
    else $error("no tracking after write");
  a_ext_hold: assert property ( // R2
    wr_ev && state_r == sar_pkg::ST_ACQ_EXT && wr_data[sar_pkg::PD_HI_BIT]
    |=> !track_r && state_r == sar_pkg::ST_CONV)
    else $error("external hold missed");
  a_int_hold: assert property ( // R3
    state_r == sar_pkg::ST_ACQ_INT && tick && !wr_ev && cnt_r == 4'h3
    |=> !track_r && state_r == sar_pkg::ST_CONV)
    else $error("internal hold missed");
  a_conv_bound: assert property ( // R4
    state_r == sar_pkg::ST_CONV |-> cnt_r < 4'(sar_pkg::CONV_CYCLES))
    else $error("conversion too long");
  a_abort_conv: assert property ( // R5
    wr_ev && state_r == sar_pkg::ST_CONV && wr_data[sar_pkg::PD_HI_BIT] &&
    !wr_data[sar_pkg::ACQ_BIT] |=> state_r == sar_pkg::ST_ACQ_INT)
    else $error("no abort");
  a_done_low: assert property (finish |=> !done_n_r) // R9
    else $error("done flag not set");
  a_done_clear: assert property ( // R10
    (rd_ev || wr_ev) && !finish |=> done_n_r)
    else $error("done flag not cleared");
  a_high_fill: assert property ( // R18
    pin_lvl[sar_pkg::PIN_HB] && pol_uni |=> dout_r[7:4] == 4'h0)
    else $error("unipolar fill wrong");
  a_bus_float: assert property (!cs_act |=> oe_n_r) // R19
    else $error("bus driven while deselected");
  // reset itself must not disable the check of what reset leaves behind
  a_reset_clk: assert property (@(posedge clk_sys) disable iff (1'b0) // R17
    srst |=> !int_clk_r && done_n_r) else $error("reset state wrong");

  c_int_conv: cover property (state_r == sar_pkg::ST_ACQ_INT ##[1:300]
    finish);
  c_ext_conv: cover property (state_r == sar_pkg::ST_ACQ_EXT ##[1:300]
    finish);
  c_abort: cover property (wr_ev && state_r == sar_pkg::ST_CONV);
  c_read: cover property (rd_ev && !done_n_r);
endmodule
`default_nettype wire

// ---- verif/host_bus_model.sv ----
`default_nettype none
module host_bus_model (
  input wire logic clk_sys,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic high_byte_select,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    high_byte_select = 1'b0;
    data_in = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // strobes stay long enough for the three-stage pin filter
  task automatic strobe_write(input logic [7:0] v, input logic sel);
    @(posedge clk_sys);
    cs_n <= ~sel;
    data_in <= v;
    repeat (4) @(posedge clk_sys);
    wr_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    // a released bus must not keep showing the old byte
    data_in <= ~v;
    @(posedge clk_sys);
  endtask

  task automatic strobe_read(input logic sel, input logic hb,
                             output logic [7:0] v, output logic oe_n);
    @(posedge clk_sys);
    cs_n <= ~sel;
    high_byte_select <= hb;
    repeat (4) @(posedge clk_sys);
    rd_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    v = data_out;
    oe_n = data_oe_n;
    rd_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ---- verif/sar_adc_control_sequencer_test.sv ----
`default_nettype none
module sar_adc_control_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 2;
  localparam int ACQ = sar_pkg::ACQ_EDGES;
  localparam int CONV = sar_pkg::CONV_CYCLES;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic conv_clk_pin = 1'b0;
  logic [11:0] ain = 12'h000;
  logic cmp_in, cs_n, wr_n, rd_n, high_byte_select, data_oe_n, done_n;
  logic hold_capacitor_track, neg_to_common, full_power_down, standby;
  logic int_clk_sel;
  logic [7:0] data_in, data_out;
  logic [11:0] dac_code, stat;
  logic [2:0] pos_channel, neg_channel;
  int errors = 0;
  int total_checks = 0;

  always #20 clk_sys = ~clk_sys;
  always
  begin
    repeat (4) @(posedge clk_sys);
    conv_clk_pin <= ~conv_clk_pin;
  end
  // comparator of an ideal analog input at level ain
  assign cmp_in = (ain >= dac_code);
  assign stat = {1'b0, hold_capacitor_track, int_clk_sel, full_power_down,
                 standby, neg_to_common, pos_channel, neg_channel};

  sar_adc_control_sequencer #(.INT_DIV(DIV)) sar_adc_control_sequencer_inst (
    .clk_sys(clk_sys), .srst(srst), .clk_en(1'b1), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .high_byte_select(high_byte_select),
    .conv_clk_pin(conv_clk_pin), .data_in(data_in), .cmp_in(cmp_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .done_n(done_n),
    .hold_capacitor_track(hold_capacitor_track), .dac_code(dac_code),
    .pos_channel(pos_channel), .neg_channel(neg_channel),
    .neg_to_common(neg_to_common), .full_power_down(full_power_down),
    .standby(standby), .int_clk_sel(int_clk_sel));

  host_bus_model host_bus_model_inst (
    .clk_sys(clk_sys), .data_out(data_out), .data_oe_n(data_oe_n),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .high_byte_select(high_byte_select), .data_in(data_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sel 0 waits for hold, sel 1 for the done flag
  task automatic wait_low(input logic sel, output int n);
    n = 0;
    while ((sel ? done_n : hold_capacitor_track) !== 1'b0)
    begin
      @(posedge clk_sys);
      n++;
      if (n > 1000)
      begin
        errors++;
        close_out();
      end
    end
  endtask

  task automatic read_result(input logic [11:0] exp, input logic bip);
    logic [7:0] v;
    logic oe;
    host_bus_model_inst.strobe_read(1'b1, 1'b0, v, oe);
    check({11'h000, oe}, 12'h000);
    check({4'h0, v}, {4'h0, exp[7:0]});
    host_bus_model_inst.strobe_read(1'b1, 1'b1, v, oe);
    check({4'h0, v}, {4'h0, {4{bip & exp[11]}}, exp[11:8]});
    check({11'h000, done_n}, 12'h001);
  endtask

  task automatic conv_int(input logic [7:0] c, input logic [11:0] st,
                          input logic [11:0] a, input logic abort);
    int n;
    ain <= a;
    host_bus_model_inst.strobe_write(c, 1'b1);
    check(stat, st);
    wait_low(1'b0, n);
    check({11'h000, n >= (ACQ-1)*DIV-1 && n <= ACQ*DIV+1}, 12'h001);
    if (abort)
    begin
      repeat (4) @(posedge clk_sys);
      host_bus_model_inst.strobe_write(c, 1'b1);
      check({stat[11:1], done_n}, st | 12'h001);
      wait_low(1'b0, n);
    end
    wait_low(1'b1, n);
    check({11'h000, n >= CONV*DIV-1 && n <= CONV*DIV+2}, 12'h001);
    read_result(c[3] ? a : a ^ 12'h800, ~c[3]);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    logic [7:0] v;
    logic oe;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    check({8'h00, done_n, int_clk_sel, full_power_down, data_oe_n},
          12'h00b);
    conv_int(8'h9d, 12'h66c, 12'h9c6, 1'b0);
    conv_int(8'h82, 12'h613, 12'h3a5, 1'b1);
    host_bus_model_inst.strobe_write(8'h00, 1'b1);
    check(stat, 12'h701);
    host_bus_model_inst.strobe_write(8'h40, 1'b1);
    check(stat, 12'h681);
    repeat (60) @(posedge clk_sys);
    check({11'h000, done_n}, 12'h001);
    // external acquisition on the free-running external clock
    ain <= 12'h0f1;
    host_bus_model_inst.strobe_write(8'he1, 1'b1);
    check(stat, 12'h408);
    repeat (40) @(posedge clk_sys);
    check(stat, 12'h408);
    host_bus_model_inst.strobe_write(8'hc1, 1'b1);
    check(stat, 12'h008);
    wait_low(1'b1, n);
    check({11'h000, n >= CONV*8-8 && n <= CONV*8+8}, 12'h001);
    host_bus_model_inst.strobe_write(8'h9d, 1'b0);
    check({stat[11:1], done_n}, 12'h008);
    host_bus_model_inst.strobe_read(1'b0, 1'b0, v, oe);
    check({10'h000, oe, done_n}, 12'h002);
    read_result(12'h8f1, 1'b1);
    // a fresh write, not a read, must clear a pending done flag
    host_bus_model_inst.strobe_write(8'h9d, 1'b1);
    wait_low(1'b1, n);
    host_bus_model_inst.strobe_write(8'h40, 1'b1);
    check({stat[11:1], done_n}, 12'h681);
    close_out();
  end
endmodule
`default_nettype wire
